/* pma_defs.vh */
// Constants shared by the macrocell array design: bus map, fields, resets and timing.
`ifndef PMA_DEFS_VH
`define PMA_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets on the bus.
// ----------------------------------------------------------------
`define PMA_ADR_CTRL 8'h00
`define PMA_ADR_CELL_CFG 8'h04
`define PMA_ADR_TERM_SEL 8'h08
`define PMA_ADR_TERM_LO 8'h0C
`define PMA_ADR_TERM_HI 8'h10
`define PMA_ADR_STATUS 8'h14

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define PMA_CTRL_RUN_BIT 0
`define PMA_CFG_PATH_LSB 0
`define PMA_CFG_POL_LSB 16
`define PMA_STAT_Q_LSB 0
`define PMA_STAT_PIN_LSB 16
`define PMA_STAT_PRELOAD_BIT 30
`define PMA_STAT_READY_BIT 31
`define PMA_CTRL_RESET 1'h0
`define PMA_CFG_RESET 10'h000
`define PMA_TERM_SEL_RESET 7'h00

// ----------------------------------------------------------------
// Timing: figures in ns, counts at the system clock rate.
// ----------------------------------------------------------------
`define PMA_CLK_PERIOD_NS 40
`define PMA_POWERUP_CLEAR_NS 1000
`define PMA_PRELOAD_SETTLE_NS 100
`define PMA_POWERUP_CYC ((`PMA_POWERUP_CLEAR_NS + `PMA_CLK_PERIOD_NS - 1) / `PMA_CLK_PERIOD_NS)
`define PMA_SETTLE_CYC ((`PMA_PRELOAD_SETTLE_NS + `PMA_CLK_PERIOD_NS - 1) / `PMA_CLK_PERIOD_NS)

`endif

/* pma_sync.v */
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`default_nettype none

module pma_sync #(
  parameter W = 1
) (
  input wire sys_clk, // System clock.
  input wire resetn, // Asynchronous reset, active low.
  input wire [W-1:0] asyncIn, // Raw pin levels.
  output reg [W-1:0] syncOut_q // Levels safe to use.
);

  reg [W-1:0] stage1_q;

  // --------------------------------------------------------------
  // Synchroniser stages
  // --------------------------------------------------------------
  // The first stage feeds only the second, so a metastable sample never reaches logic.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= {W{1'b0}};
      syncOut_q <= {W{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      syncOut_q <= stage1_q;
    end
  end

endmodule
`default_nettype wire

/* pma_and_array.v */
// Programmable AND plane: each product term over true and complement rails.
`default_nettype none

module pma_and_array #(
  parameter NIN = 22,
  parameter NTERM = 92
) (
  input wire [NIN-1:0] arrayIn, // Input and feedback signals.
  input wire [NTERM*2*NIN-1:0] fuseFlat, // Connection bits, one row per term.
  output wire [NTERM-1:0] termOut // Product term results.
);

  wire [2*NIN-1:0] rails;

  // --------------------------------------------------------------
  // Input buffers
  // --------------------------------------------------------------
  // Even column is the true copy, odd column the complement.
  genvar i;
  generate
    for (i = 0; i < NIN; i = i + 1) begin : gRail
      assign rails[2*i] = arrayIn[i]; // [RULE9]
      assign rails[2*i+1] = ~arrayIn[i]; // [RULE9]
    end
  endgenerate

  // --------------------------------------------------------------
  // Product terms
  // --------------------------------------------------------------
  // An open column forces a one into the AND, so a fully open row is high,
  // and a row tied to both rails of one signal always sees a zero.
  genvar t;
  generate
    for (t = 0; t < NTERM; t = t + 1) begin : gTerm
      assign termOut[t] = &(rails | ~fuseFlat[t*2*NIN +: 2*NIN]); // [RULE1] [RULE2]
    end
  endgenerate

endmodule
`default_nettype wire

/* pma_top.v */
// Fuse-configured sum-of-products device with ten output cells and a bus-loaded pattern.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`include "pma_defs.vh"
`default_nettype none

// Notes on behaviour
// [RULE1] Term with no connections reads high.
// [RULE2] Term using both rails reads low.
// [RULE3] Twelve dedicated inputs, ten bidirectional output cells.
// [RULE4] Two bits choose registered/combinatorial and polarity.
// [RULE5] Unprogrammed bit is zero, picks zero path.
// [RULE6] Cell flops capture on device clock rise.
// [RULE7] Registered path: feedback is inverted flop.
// [RULE8] Combinatorial path: bypass flop, feedback from pin.
// [RULE9] Each input gives true and complement rails.
// [RULE10] Flops cleared low within power-up interval.
// [RULE11] Board avoids clock edges until setup met.
// [RULE12] Pins invalid 100 ns after preload ends.
// [RULE13] Polarity bit one gives active-high output.
// [RULE14] Preset term loads flops high on edge.
// [RULE15] Clear term forces flops low at once.
// [RULE16] Each cell buffer enabled by own term.
// [RULE17] Pattern and cell bits are static data.
// [RULE18] Polarity applied after register/bypass selection.
module pma_top #(
  parameter NCELL = 10,
  parameter NDED = 11,
  parameter PT = 8
) (
  input wire sys_clk, // System clock, 25 MHz.
  input wire resetn, // Asynchronous reset, active low.
  input wire wb_cyc_i, // Bus cycle.
  input wire wb_stb_i, // Bus strobe.
  input wire wb_we_i, // Write when high.
  input wire [7:0] wb_adr_i, // Byte address.
  input wire [3:0] wb_sel_i, // Byte lanes.
  input wire [31:0] wb_dat_i, // Write data.
  output reg [31:0] wb_dat_o, // Read data.
  output reg wb_ack_o, // Acknowledge.
  input wire clockOrInputZero, // Device clock pin, also array input zero.
  input wire [NDED-1:0] dedicatedIn, // Dedicated inputs one to eleven.
  input wire preloadEnable, // Preload enable pin, active high.
  input wire [NCELL-1:0] cellPinIn, // Level seen on each cell pin.
  output reg [NCELL-1:0] cellPinOut_q, // Level driven on each cell pin.
  output reg [NCELL-1:0] cellPinOe_q // Drive enable of each cell pin.
);

  // --------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------
  localparam NIN = 1 + NDED + NCELL; // [RULE3]
  localparam RW = 2 * NIN;
  localparam NTERM = NCELL * (PT + 1) + 2;
  localparam OE_BASE = NCELL * PT;
  localparam AR_IDX = NCELL * (PT + 1);
  localparam SP_IDX = AR_IDX + 1;
  localparam integer PU_CYC_I = `PMA_POWERUP_CYC;
  localparam integer SETTLE_CYC_I = `PMA_SETTLE_CYC;
  localparam [5:0] PU_CYC = PU_CYC_I[5:0];
  localparam [2:0] SETTLE_CYC = SETTLE_CYC_I[2:0];

  // Merges write data into a word under the byte lanes.
  function [31:0] laneMerge;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] sel;
    integer b;
    begin
      laneMerge = oldWord;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          laneMerge[8*b +: 8] = newWord[8*b +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  reg runEnable_q;
  reg [NCELL-1:0] pathSel_q;
  reg [NCELL-1:0] polaritySel_q;
  reg [6:0] termSel_q;
  reg [RW-1:0] fuseRow_q [0:NTERM-1];
  reg [NCELL-1:0] cellQ_q;
  reg [NCELL-1:0] cellQ_d;
  reg devClkPrev_q;
  reg preloadPrev_q;
  reg [5:0] powerupCnt_q;
  reg [2:0] settleCnt_q;
  reg [31:0] rdData;
  reg [NCELL-1:0] pinOut_d;
  reg [NCELL-1:0] pinOe_d;
  wire clkSync;
  wire [NDED-1:0] dedSync;
  wire preloadSync;
  wire [NCELL-1:0] pinSync;
  wire [NCELL-1:0] feedback;
  wire [NCELL-1:0] sumOut;
  wire [NCELL-1:0] pathOut;
  wire [NTERM-1:0] terms;
  wire [NTERM*RW-1:0] fuseFlat;
  wire devClkRise;
  wire powerupDone;
  wire pinsValid;
  wire busReq;
  wire busWrite;
  wire [31:0] rowLo;
  wire [31:0] rowHi;
  wire selValid;
  wire [31:0] cfgMerged;
  wire [31:0] hiMerged;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  // Every board level passes two flops before the array sees it.
  pma_sync #(
    .W(2 + NDED + NCELL)
  ) uSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn({preloadEnable, cellPinIn, dedicatedIn, clockOrInputZero}),
    .syncOut_q({preloadSync, pinSync, dedSync, clkSync})
  );

  // Rising edge of the device clock, taken from the synchronised level.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      devClkPrev_q <= 1'b0;
      preloadPrev_q <= 1'b0;
    end else begin
      devClkPrev_q <= clkSync;
      preloadPrev_q <= preloadSync;
    end
  end

  // The board holds the clock still until setup is met, so an edge soon after reset is still taken as real.
  assign devClkRise = clkSync & ~devClkPrev_q; // [RULE6] [RULE11]

  // --------------------------------------------------------------
  // Power-up clear and preload settle timers
  // --------------------------------------------------------------
  // Outputs stay off until the clear interval has run out.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      powerupCnt_q <= 6'h00;
    end else if (powerupCnt_q != PU_CYC) begin
      powerupCnt_q <= powerupCnt_q + 6'h01; // [RULE10]
    end
  end

  assign powerupDone = (powerupCnt_q == PU_CYC);

  // After preload is released the pins are held off for the settle time.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settleCnt_q <= 3'h0;
    end else if (preloadSync) begin
      settleCnt_q <= 3'h0;
    end else if (preloadPrev_q) begin
      settleCnt_q <= SETTLE_CYC; // [RULE12]
    end else if (settleCnt_q != 3'h0) begin
      settleCnt_q <= settleCnt_q - 3'h1;
    end
  end

  assign pinsValid = powerupDone & ~preloadSync & ~preloadPrev_q & (settleCnt_q == 3'h0); // [RULE12]

  // --------------------------------------------------------------
  // AND and OR planes
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NTERM; g = g + 1) begin : gFlat
      assign fuseFlat[g*RW +: RW] = fuseRow_q[g];
    end
  endgenerate

  // Array input order: clock pin, dedicated inputs, then cell feedback.
  pma_and_array #(
    .NIN(NIN),
    .NTERM(NTERM)
  ) uArray (
    .arrayIn({feedback, dedSync, clkSync}),
    .fuseFlat(fuseFlat),
    .termOut(terms)
  );

  // Each cell sums its own group of terms; feedback and path follow the path bit.
  generate
    for (g = 0; g < NCELL; g = g + 1) begin : gCell
      assign sumOut[g] = |terms[g*PT +: PT];
      assign pathOut[g] = pathSel_q[g] ? sumOut[g] : cellQ_q[g]; // [RULE4] [RULE5] [RULE7] [RULE8]
      assign feedback[g] = pathSel_q[g] ? pinSync[g] : ~cellQ_q[g]; // [RULE7] [RULE8]
    end
  endgenerate

  // --------------------------------------------------------------
  // Cell flip-flops
  // --------------------------------------------------------------
  // Clear wins over preload data, preload data over preset, preset over sums.
  // The clear term acts on any system edge, not waiting for the device clock.
  always @* begin
    cellQ_d = cellQ_q;
    if (!powerupDone) begin
      cellQ_d = {NCELL{1'b0}}; // [RULE10]
    end else if (terms[AR_IDX]) begin
      cellQ_d = {NCELL{1'b0}}; // [RULE15]
    end else if (devClkRise) begin
      if (preloadSync) begin
        cellQ_d = pinSync;
      end else if (terms[SP_IDX]) begin
        cellQ_d = {NCELL{1'b1}}; // [RULE14]
      end else begin
        cellQ_d = sumOut; // [RULE6]
      end
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cellQ_q <= {NCELL{1'b0}}; // [RULE10]
    end else begin
      cellQ_q <= cellQ_d;
    end
  end

  // --------------------------------------------------------------
  // Output buffers
  // --------------------------------------------------------------
  // Polarity comes last, so preset and clear describe the flop, not the pin.
  always @* begin
    pinOut_d = ~(pathOut ^ polaritySel_q); // [RULE13] [RULE18]
    pinOe_d = {NCELL{1'b0}};
    if (runEnable_q && pinsValid) begin
      pinOe_d = terms[OE_BASE +: NCELL]; // [RULE16]
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cellPinOut_q <= {NCELL{1'b0}};
      cellPinOe_q <= {NCELL{1'b0}};
    end else begin
      cellPinOut_q <= pinOut_d;
      cellPinOe_q <= pinOe_d;
    end
  end

  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  // One wait state: ack rises the cycle after the request and drops after one cycle.
  // A write commits at the edge where the master sees ack, while its request still stands.
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign selValid = (termSel_q < NTERM);
  assign rowLo = selValid ? fuseRow_q[termSel_q][31:0] : 32'h00000000;
  assign rowHi = selValid ? {{(64 - RW){1'b0}}, fuseRow_q[termSel_q][RW-1:32]} : 32'h00000000;

  // Lane-merged words; each is cut to its field width where it is stored.
  assign cfgMerged = laneMerge({6'h00, polaritySel_q, 6'h00, pathSel_q}, wb_dat_i, wb_sel_i);
  assign hiMerged = laneMerge(rowHi, wb_dat_i, wb_sel_i);

  // Read data is zero for unmapped addresses and unused bits.
  always @* begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      `PMA_ADR_CTRL: rdData[`PMA_CTRL_RUN_BIT] = runEnable_q;
      `PMA_ADR_CELL_CFG: begin
        rdData[`PMA_CFG_PATH_LSB +: NCELL] = pathSel_q;
        rdData[`PMA_CFG_POL_LSB +: NCELL] = polaritySel_q;
      end
      `PMA_ADR_TERM_SEL: rdData[6:0] = termSel_q;
      `PMA_ADR_TERM_LO: rdData = rowLo;
      `PMA_ADR_TERM_HI: rdData = rowHi;
      `PMA_ADR_STATUS: begin
        rdData[`PMA_STAT_Q_LSB +: NCELL] = cellQ_q;
        rdData[`PMA_STAT_PIN_LSB +: NCELL] = cellPinOut_q;
        rdData[`PMA_STAT_PRELOAD_BIT] = preloadSync;
        rdData[`PMA_STAT_READY_BIT] = pinsValid;
      end
      default: rdData = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h00000000;
    end
  end

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  // Reset leaves every bit unprogrammed: zero, so each mux takes its zero path.
  // Rewriting while running is not blocked; software should clear run first.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      runEnable_q <= `PMA_CTRL_RESET;
      pathSel_q <= `PMA_CFG_RESET; // [RULE5]
      polaritySel_q <= `PMA_CFG_RESET; // [RULE5]
      termSel_q <= `PMA_TERM_SEL_RESET;
    end else if (busWrite) begin
      case (wb_adr_i)
        `PMA_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            runEnable_q <= wb_dat_i[`PMA_CTRL_RUN_BIT];
          end
        end
        `PMA_ADR_CELL_CFG: begin
          pathSel_q <= cfgMerged[`PMA_CFG_PATH_LSB +: NCELL]; // [RULE17]
          polaritySel_q <= cfgMerged[`PMA_CFG_POL_LSB +: NCELL];
        end
        `PMA_ADR_TERM_SEL: begin
          if (wb_sel_i[0]) begin
            termSel_q <= wb_dat_i[6:0];
          end
        end
        default: begin
          runEnable_q <= runEnable_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Fuse pattern storage
  // --------------------------------------------------------------
  // Reset connects every column, like an unprogrammed part: all terms low.
  integer r;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (r = 0; r < NTERM; r = r + 1) begin
        fuseRow_q[r] <= {RW{1'b1}};
      end
    end else if (busWrite && selValid) begin
      if (wb_adr_i == `PMA_ADR_TERM_LO) begin
        fuseRow_q[termSel_q][31:0] <= laneMerge(rowLo, wb_dat_i, wb_sel_i); // [RULE17]
      end else if (wb_adr_i == `PMA_ADR_TERM_HI) begin
        fuseRow_q[termSel_q][RW-1:32] <= hiMerged[RW-33:0];
      end
    end
  end

endmodule
`default_nettype wire

/* pma_top_assertions.sv */
// Checker for the macrocell array: bus handshake and pin drive-enable timing.
`default_nettype none
module pma_checker #(
  parameter NCELL = 10
) (
  input wire logic sys_clk, // System clock.
  input wire logic resetn, // Reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write when high.
  input wire logic [7:0] wb_adr_i, // Byte address.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic preloadEnable, // Preload pin.
  input wire logic [NCELL-1:0] cellPinOe_q // Pin drive enables.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] upCnt_q;
  // Edges since reset release; it saturates so it never wraps back into the quiet window.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upCnt_q <= 5'h00;
    end else if (upCnt_q != 5'h1F) begin
      upCnt_q <= upCnt_q + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack1; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_next; s_req |=> s_ack1; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered in the next cycle");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");
  property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o); endproperty
  a_ack_src: assert property (p_ack_src) else $error("acknowledge without a request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside acknowledge");
  property p_unmapped; wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h14 |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_powerup; upCnt_q < 5'h19 |-> cellPinOe_q == '0; endproperty
  a_powerup: assert property (p_powerup) else $error("pin driven during power-up clear");
  property p_preload_hold; preloadEnable [*5] |-> cellPinOe_q == '0; endproperty
  a_preload_hold: assert property (p_preload_hold) else $error("pin driven in preload");
  property p_preload_settle; $fell(preloadEnable) |-> (cellPinOe_q == '0) [*3]; endproperty
  a_preload_settle: assert property (p_preload_settle) else $error("pin driven too soon after preload");
endmodule
bind pma_top pma_checker #(.NCELL(NCELL)) i_pma_checker (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .preloadEnable(preloadEnable), .cellPinOe_q(cellPinOe_q));
`default_nettype wire

/* pma_board.sv */
// Board model that resolves the ten cell pins between the device and board drivers.
`default_nettype none
module pma_board (
  input wire logic sys_clk, // System clock.
  input wire logic [9:0] pinOut, // Device drive values.
  input wire logic [9:0] pinOe, // Device drive enables.
  input wire logic [9:0] boardEn, // Board drives the pin when high.
  input wire logic [9:0] boardVal, // Board drive values.
  output logic [9:0] pinLevel // Resolved pin levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] last_q = 10'h000;
  // A floating pin shows the inverse of the last level driven onto it, so stale data never passes as valid.
  always_ff @(posedge sys_clk) last_q <= ((pinOe | boardEn) & pinLevel) | (~(pinOe | boardEn) & last_q);
  // The device wins when it drives; the board only fills in where the device is off.
  always_comb begin
    for (int i = 0; i < 10; i++) pinLevel[i] = pinOe[i] ? pinOut[i] : boardEn[i] ? boardVal[i] : ~last_q[i];
  end
endmodule
`default_nettype wire

/* pma_top_test.sv */
// Self-checking bench for the macrocell array: bus tasks and pin scenarios.
`default_nettype none
module pma_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, cyc, stb, we, ack, devClk, pre;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR, r;
  logic [10:0] ded;
  logic [9:0] pinIn, pinOut, pinOe, bEn, bVal;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // Device and board
  // ----------------------------------------------------------------
  pma_top i_pma_top (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .clockOrInputZero(devClk),
    .dedicatedIn(ded), .preloadEnable(pre), .cellPinIn(pinIn), .cellPinOut_q(pinOut), .cellPinOe_q(pinOe));
  pma_board i_pma_board (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .boardEn(bEn), .boardVal(bVal),
    .pinLevel(pinIn));
  // Clock and hang guard; the scenarios need well under two thousand cycles.
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stays put until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    r = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  task automatic row(input logic [6:0] t, input logic [31:0] lo, input logic [11:0] hi);
    wb(1'b1, 8'h08, {25'h0, t});
    wb(1'b1, 8'h0C, lo);
    wb(1'b1, 8'h10, {20'h0, hi});
  endtask
  // Device clock pulse, with quiet time before the rise so every setup is met.
  task automatic pulse();
    repeat (3) @(posedge sys_clk);
    devClk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    devClk <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {sys_clk, resetn, cyc, stb, we, devClk, pre, adr, datW, ded, bEn, bVal} = '0;
    sel = 4'hF;
    waitn(3);
    resetn <= 1'b1;
    rd(8'h14, 32'h03FF03FF, 32'h03FF0000);
    row(7'h50, 32'h0, 12'h0);
    wb(1'b1, 8'h00, 32'h1);
    waitn(6);
    chk({22'h0, pinOe}, 32'h0);
    rd(8'h04, 32'hFFFFFFFF, 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    row(7'h5C, 32'hFFFFFFFF, 12'hFFF);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0);
    waitn(30);
    chk({22'h0, pinOe}, 32'h1);
    $display("reset test done");
    wb(1'b1, 8'h04, 32'h00010001);
    row(7'h00, 32'h0, 12'h0);
    row(7'h50, 32'h0, 12'h0);
    wb(1'b1, 8'h00, 32'h1);
    waitn(6);
    chk(pinOut[0], 1'b1);
    chk({22'h0, pinOe}, 32'h1);
    wb(1'b1, 8'h04, 32'h1);
    waitn(6);
    chk(pinOut[0], 1'b0);
    wb(1'b1, 8'h04, 32'h00010001);
    for (int i = 0; i < 4; i++) begin
      row(7'h00, i[1] ? 32'h8 : 32'h4, 12'h0);
      ded[0] <= i[0];
      waitn(6);
      chk(pinOut[0], i[0] ^ i[1]);
    end
    row(7'h00, 32'hC, 12'h0);
    waitn(6);
    chk(pinOut[0], 1'b0);
    wb(1'b1, 8'h04, 32'h00030003);
    row(7'h08, 32'h01000000, 12'h0);
    row(7'h51, 32'h0, 12'h0);
    row(7'h50, 32'hFFFFFFFF, 12'hFFF);
    bEn[0] <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      bVal[0] <= v[0];
      waitn(6);
      chk(pinOut[1], v[0]);
    end
    $display("combinatorial test done");
    wb(1'b1, 8'h04, 32'h00070003);
    row(7'h10, 32'h10000000, 12'h0);
    for (int i = 0; i < 4; i++) begin
      pulse();
      rd(8'h14, 32'h4, i[0] ? 32'h0 : 32'h4);
    end
    wb(1'b1, 8'h04, 32'h00030003);
    waitn(6);
    chk(pinOut[2], 1'b1);
    rd(8'h14, 32'h4, 32'h0);
    $display("registered test done");
    row(7'h5B, 32'h0, 12'h0);
    rd(8'h14, 32'h3FC, 32'h0);
    pulse();
    rd(8'h14, 32'h3FC, 32'h3FC);
    row(7'h5B, 32'hFFFFFFFF, 12'hFFF);
    row(7'h5A, 32'h0, 12'h0);
    waitn(4);
    rd(8'h14, 32'h3FC, 32'h0);
    row(7'h5A, 32'hFFFFFFFF, 12'hFFF);
    $display("preset and clear test done");
    pre <= 1'b1;
    bEn <= 10'h3FF;
    bVal <= 10'h2A4;
    waitn(6);
    chk({22'h0, pinOe}, 32'h0);
    pulse();
    rd(8'h14, 32'h400003FC, 32'h400002A4);
    pre <= 1'b0;
    bEn <= 10'h001;
    waitn(12);
    chk(pinOe[1], 1'b1);
    $display("preload test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
